// [rtl/rir_params.svh]
// Constants of the infrared receiver status and path configuration block.
// Assumes: included by bare name; types live in rir_pkg.
`ifndef RIR_PARAMS_SVH
`define RIR_PARAMS_SVH

// Register indices; the byte address on APB is four times the index
`define RX_BUFFER_IDX       8'h00
`define LINE_STATUS_IDX     8'h05
`define PATH_CONFIG_IDX     8'h06
`define INT_STATUS_IDX      8'h08
`define INT_MASK_IDX        8'h09

// Line status fields
`define ST_TIMEOUT_BIT      2
`define ST_OVERRUN_BIT      1
`define ST_READY_BIT        0

// Path configuration fields
`define CFG_SMP_HI          7
`define CFG_SMP_LO          6
`define CFG_LP_HI           5
`define CFG_LP_LO           4
`define CFG_DM_HI           3
`define CFG_DM_LO           2
`define CFG_PREDIV_BIT      1
`define CFG_INV_BIT         0

// Reset values
`define CFG_RESET           8'h00
`define INT_MASK_RESET      3'h0

// Timing
`define CLK_HZ              40000000
`define BAUD_SRC_HZ         24000000
`define PREDIV_RATIO        13
`define RX_TIMEOUT_PERIODS  32
`define LP_FILTER_DEPTH     4

`endif

// [rtl/rir_pkg.sv]
// Types of the infrared receiver status and path configuration block.
// Assumes: compiled before the design modules.
`default_nettype none
package rir_pkg;

  typedef enum logic [1:0] {
    SMP_PERIOD, SMP_OVER, SMP_RESYNC, SMP_FIFO_TEST
  } sampling_e;

  typedef enum logic [1:0] {
    LP_RAW, LP_BP_R, LP_BP_D, LP_RSVD
  } lp_src_e;

  typedef enum logic [1:0] {
    DM_BOTH, DM_BP_ONLY, DM_RSVD, DM_BYPASS
  } demod_e;

  typedef struct packed {
    logic [7:0]  prdata;
    logic [7:0]  cfg;
    logic [7:0]  rbuf;
    logic        rdy;
    logic        to;
    logic        ov;
    logic [2:0]  int_st;
    logic [2:0]  int_mask;
    logic [5:0]  ph;
    logic [3:0]  pre_cnt;
    logic [15:0] bit_cnt;
    logic        sync1;
    logic        sync2;
    logic        prev;
    logic        run_act;
    logic [6:0]  run;
    logic [7:0]  shreg;
    logic [2:0]  nbits;
    logic [15:0] idle;
  } rx_state_s;

endpackage
`default_nettype wire

// [rtl/lp_filter.sv]
// Low-pass glitch filter: output follows the input once it held for DEPTH
// clocks. Assumes: input already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "rir_params.svh"
module lp_filter
  import rir_pkg::*;
#(
  parameter int DEPTH = `LP_FILTER_DEPTH
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } lp_state_s;

  lp_state_s q;
  lp_state_s n;

  // Integrator saturating at both ends gives hysteresis against glitches
  always_comb begin
    n = q;
    if (din && q.cnt != FULL) begin
      n.cnt = q.cnt + CW'(1);
    end else if (!din && q.cnt != '0) begin
      n.cnt = q.cnt - CW'(1);
    end
    if (n.cnt == FULL) begin
      n.out = 1'b1;
    end else if (n.cnt == '0) begin
      n.out = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign dout = q.out;

  AST_LP_STEADY: // [R8]
    assert property (@(posedge clk) disable iff (srst)
      $changed(dout) |-> $past(din) == dout)
    else $error("filter output moved against its input");

endmodule
`default_nettype wire

// [rtl/rir_rx_ctrl.sv]
// Infrared receiver: line status, path configuration, sampling decoder,
// baud pre-divisor and a one-byte receive buffer behind an APB slave.
// Assumes: APB master on clk; band-pass outputs and frame status timeout
// come from neighbouring logic on clk; the receive pin is asynchronous.
//
// Functional notes
// [R1] Receive timeout is set on a buffer or frame status timeout and cleared by a status read.
// [R2] Overrun is set when a byte arrives into a full buffer and cleared by a status read.
// [R3] Data-ready stays high while a byte waits and drops once it is taken.
// [R4] The two-bit sampling field picks period, oversampling, resync or FIFO test mode.
// [R5] In period mode each byte holds the bit value and the run length minus one.
// [R6] In a period byte a value of 0 means energy and 1 means none, swapped by inversion.
// [R7] The invert bit inverts the received signal before decoding.
// [R8] The low-pass source field picks raw pin, R band-pass or D band-pass.
// [R9] The demodulation field picks both filters, band-pass only or bypass.
// [R10] The pre-divisor bit divides the 24 MHz source by 13 or passes it as is.
// [R11] Reserved status bits read as zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "rir_params.svh"
module rir_rx_ctrl
  import rir_pkg::*;
#(
  parameter int TIMEOUT_PERIODS = `RX_TIMEOUT_PERIODS
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        infrared_receive_pin,
  input  wire logic        bp_r_in,
  input  wire logic        bp_d_in,
  input  wire logic        frame_status_timeout,
  input  wire logic [15:0] bit_period_div,
  output logic             baud_tick,
  output logic             irq
);
  localparam logic [7:0] A_BUF  = 8'(`RX_BUFFER_IDX * 4);
  localparam logic [7:0] A_STAT = 8'(`LINE_STATUS_IDX * 4);
  localparam logic [7:0] A_CFG  = 8'(`PATH_CONFIG_IDX * 4);
  localparam logic [7:0] A_INTS = 8'(`INT_STATUS_IDX * 4);
  localparam logic [7:0] A_MASK = 8'(`INT_MASK_IDX * 4);
  localparam logic [6:0] PH_STEP = 7'(`BAUD_SRC_HZ / 1000000);
  localparam logic [6:0] PH_MOD  = 7'(`CLK_HZ / 1000000);
  localparam logic [3:0] PRE_LAST = 4'(`PREDIV_RATIO - 1);
  localparam logic [15:0] TO_LAST = 16'(TIMEOUT_PERIODS - 1);

  rx_state_s q;
  rx_state_s n;

  sampling_e   smp_mode;
  lp_src_e     lp_src;
  demod_e      dm_sel;
  logic        lp_in;
  logic        lp_out;
  logic        path;
  logic        sig;
  logic        setup;
  logic        acc;
  logic        rd;
  logic        wr;
  logic        hit;
  logic        src_tick;
  logic        pre_tick;
  logic        smp_tick;
  logic        push;
  logic [7:0]  push_byte;
  logic        buf_rd;
  logic        ev_to;
  logic        ev_ov;
  logic        ev_rx;
  logic [6:0]  ph_sum;
  logic [15:0] div_last;
  logic [7:0]  rd_mux;

  assign smp_mode = sampling_e'(q.cfg[`CFG_SMP_HI:`CFG_SMP_LO]);
  assign lp_src   = lp_src_e'(q.cfg[`CFG_LP_HI:`CFG_LP_LO]);
  assign dm_sel   = demod_e'(q.cfg[`CFG_DM_HI:`CFG_DM_LO]);

  // Filter input; the reserved code falls back to the raw pin
  always_comb begin
    case (lp_src)
      LP_RAW:  lp_in = q.sync2;                           // [R8]
      LP_BP_R: lp_in = bp_r_in;                           // [R8]
      LP_BP_D: lp_in = bp_d_in;                           // [R8]
      default: lp_in = q.sync2;
    endcase
  end

  lp_filter #(
    .DEPTH (`LP_FILTER_DEPTH)
  ) u_lp (
    .clk  (clk),
    .srst (srst),
    .din  (lp_in),
    .dout (lp_out)
  );

  // Reserved demodulation code behaves as the full filter chain
  always_comb begin
    case (dm_sel)
      DM_BOTH:    path = lp_out;                          // [R9]
      DM_BP_ONLY: path = bp_r_in;                         // [R9]
      DM_BYPASS:  path = q.sync2;                         // [R9]
      default:    path = lp_out;
    endcase
  end

  assign sig = path ^ q.cfg[`CFG_INV_BIT];                // [R7]

  assign setup = psel && !penable;
  assign acc   = psel && penable;
  assign rd    = acc && !pwrite;
  assign wr    = acc && pwrite;
  assign hit   = paddr == A_BUF || paddr == A_STAT || paddr == A_CFG ||
                 paddr == A_INTS || paddr == A_MASK;
  assign buf_rd   = rd && paddr == A_BUF;
  assign ph_sum   = {1'b0, q.ph} + PH_STEP;
  assign div_last = (bit_period_div == 16'h0000) ? 16'h0000 :
                    bit_period_div - 16'h0001;

  always_comb begin
    case (paddr)
      A_BUF:   rd_mux = q.rbuf;
      A_STAT:  rd_mux = {5'h00, q.to, q.ov, q.rdy};       // [R11]
      A_CFG:   rd_mux = q.cfg;
      A_INTS:  rd_mux = {5'h00, q.int_st};
      A_MASK:  rd_mux = {5'h00, q.int_mask};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    n = q;
    src_tick  = 1'b0;
    pre_tick  = 1'b0;
    smp_tick  = 1'b0;
    push      = 1'b0;
    push_byte = 8'h00;
    ev_to     = 1'b0;
    ev_ov     = 1'b0;
    ev_rx     = 1'b0;
    n.sync1 = infrared_receive_pin;
    n.sync2 = q.sync1;

    // 24 MHz enable from the 40 MHz clock by phase accumulation
    if (ph_sum >= PH_MOD) begin
      n.ph = 6'(ph_sum - PH_MOD);
      src_tick = 1'b1;
    end else begin
      n.ph = ph_sum[5:0];
    end

    if (src_tick) begin
      if (!q.cfg[`CFG_PREDIV_BIT]) begin
        pre_tick  = 1'b1;                                 // [R10]
        n.pre_cnt = 4'h0;
      end else if (q.pre_cnt == PRE_LAST) begin
        pre_tick  = 1'b1;                                 // [R10]
        n.pre_cnt = 4'h0;
      end else begin
        n.pre_cnt = q.pre_cnt + 4'h1;
      end
    end

    if (pre_tick) begin
      if (q.bit_cnt >= div_last) begin
        smp_tick  = 1'b1;
        n.bit_cnt = 16'h0000;
      end else begin
        n.bit_cnt = q.bit_cnt + 16'h0001;
      end
    end

    if (smp_tick) begin
      n.prev = sig;
      case (smp_mode)                                     // [R4]
        SMP_PERIOD: begin
          if (!q.run_act) begin
            n.run_act = 1'b1;
            n.run     = 7'h00;
          end else if (sig == q.prev && q.run != 7'h7f) begin
            n.run = q.run + 7'h01;                        // [R5]
          end else begin
            push      = 1'b1;
            push_byte = {~q.prev, q.run};                 // [R5] [R6]
            n.run     = 7'h00;
          end
        end
        SMP_OVER, SMP_RESYNC: begin
          n.run_act = 1'b0;
          // Resync drops a partial byte so the next one starts on the edge
          if (smp_mode == SMP_RESYNC && sig != q.prev && q.nbits != 3'h0) begin
            n.shreg = {7'h00, sig};
            n.nbits = 3'h1;
          end else begin
            n.shreg = {q.shreg[6:0], sig};
            n.nbits = q.nbits + 3'h1;
            if (q.nbits == 3'h7) begin
              push      = 1'b1;
              push_byte = {q.shreg[6:0], sig};
            end
          end
        end
        default: begin
          n.run_act = 1'b0;
        end
      endcase
    end

    // Test mode lets software load the buffer directly
    if (wr && paddr == A_BUF && smp_mode == SMP_FIFO_TEST) begin
      push      = 1'b1;                                   // [R4]
      push_byte = pwdata[7:0];
    end

    if (setup && !pwrite) begin
      n.prdata = rd_mux;
    end

    // Clears first so that a same-cycle set wins
    if (rd && paddr == A_STAT) begin
      if (q.prdata[`ST_TIMEOUT_BIT]) begin
        n.to = 1'b0;                                      // [R1]
      end
      if (q.prdata[`ST_OVERRUN_BIT]) begin
        n.ov = 1'b0;                                      // [R2]
      end
    end
    if (buf_rd) begin
      n.rdy = 1'b0;                                       // [R3]
    end

    if (push) begin
      if (q.rdy && !buf_rd) begin
        n.ov  = 1'b1;                                     // [R2]
        ev_ov = 1'b1;
      end else begin
        n.rbuf = push_byte;
        n.rdy  = 1'b1;                                    // [R3]
        ev_rx  = 1'b1;
      end
    end

    // A waiting byte left unread for the timeout span raises the flag
    if (push || buf_rd || !q.rdy) begin
      n.idle = 16'h0000;
    end else if (smp_tick) begin
      if (q.idle == TO_LAST) begin
        n.idle = 16'h0000;
        n.to   = 1'b1;                                    // [R1]
        ev_to  = 1'b1;
      end else begin
        n.idle = q.idle + 16'h0001;
      end
    end
    if (frame_status_timeout) begin
      n.to  = 1'b1;                                       // [R1]
      ev_to = 1'b1;
    end

    if (wr && paddr == A_CFG) begin
      n.cfg     = pwdata[7:0];
      n.run_act = 1'b0;
      n.nbits   = 3'h0;
    end
    if (wr && paddr == A_MASK) begin
      n.int_mask = pwdata[2:0];
    end
    if (wr && paddr == A_INTS) begin
      n.int_st = q.int_st & ~pwdata[2:0];
    end
    n.int_st = n.int_st | {ev_to, ev_ov, ev_rx};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q          <= '0;
      q.cfg      <= `CFG_RESET;
      q.int_mask <= `INT_MASK_RESET;
    end else begin
      q <= n;
    end
  end

  assign prdata    = {24'h000000, q.prdata};
  assign pready    = acc;
  assign pslverr   = acc && !hit;
  assign baud_tick = pre_tick;
  assign irq       = |(q.int_st & q.int_mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_TO_SET: // [R1]
    assert property (frame_status_timeout |=> q.to)
    else $error("timeout flag missed a frame status timeout");

  AST_OV_SET: // [R2]
    assert property (push && q.rdy && !buf_rd |=> q.ov && $stable(q.rbuf))
    else $error("overrun not flagged or buffer overwritten");

  AST_OV_CLR: // [R2]
    assert property (rd && paddr == A_STAT && q.prdata[1] && !ev_ov |=> !q.ov)
    else $error("overrun flag survived a status read");

  AST_RDY_SET: // [R3]
    assert property (push && !q.rdy |=> q.rdy && q.rbuf == $past(push_byte))
    else $error("accepted byte not shown as waiting");

  AST_RDY_CLR: // [R3]
    assert property (buf_rd && !push |=> !q.rdy)
    else $error("data ready stayed after buffer read");

  AST_TEST_MODE: // [R4]
    assert property (smp_mode == SMP_FIFO_TEST && push |-> wr)
    else $error("decoder pushed data in test mode");

  AST_PERIOD_FMT: // [R6]
    assert property (push && !q.rdy && !wr && smp_mode == SMP_PERIOD
                     |=> q.rbuf[7] == !$past(q.prev))
    else $error("period byte carries wrong bit value");

  AST_INV_BYPASS: // [R7]
    assert property (dm_sel == DM_BYPASS && q.cfg[0] |-> sig == !q.sync2)
    else $error("bypass path not inverted");

  AST_PREDIV_GAP: // [R10]
    assert property (pre_tick && q.cfg[1]
                     |=> (!pre_tick || !q.cfg[1]) [*8])
    else $error("divided baud ticks too close together");

  AST_PREDIV_OFF: // [R10]
    assert property (!q.cfg[1] |-> pre_tick == src_tick)
    else $error("undivided baud tick differs from source");

  AST_RSVD: // [R11]
    assert property (setup && !pwrite && paddr == A_STAT
                     |=> q.prdata[7:3] == 5'h00)
    else $error("reserved status bits read nonzero");

endmodule
`default_nettype wire

// [dv/ir_remote_model.sv]
// Remote control model: drives the receive pin, high means IR energy.
// Assumes: bench calls burst right after a rising edge of clk.
`timescale 1ns/100ps
`default_nettype none
module ir_remote_model (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;

  // Pin is always driven: no energy between bursts, never left floating
  task automatic burst(input int gap, input int len);
    repeat (gap) @(posedge clk);
    pin <= 1'b1;
    repeat (len) @(posedge clk);
    pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/test_ir_receiver_status_config.sv]
// Bench for the infrared receiver status and path configuration block.
// Assumes: zero wait state APB slave; sample tick every 20 baud ticks.
`timescale 1ns/100ps
`default_nettype none
module test_ir_receiver_status_config;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        ir_pin, frame_status_timeout, baud_tick, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        rerr;
  logic [15:0] bit_period_div;
  int          err_count, n_compared;

  rir_rx_ctrl #(.TIMEOUT_PERIODS(16)) rir_rx_ctrl_i (
    .clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .infrared_receive_pin(ir_pin), .bp_r_in(ir_pin), .bp_d_in(~ir_pin),
    .frame_status_timeout(frame_status_timeout),
    .bit_period_div(bit_period_div), .baud_tick(baud_tick), .irq(irq)
  );
  ir_remote_model ir_remote_model_i (.clk(clk), .pin(ir_pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // One transfer; entered right after a rising edge, returns one idle edge
  // later so that a following call never retoggles psel in one step
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk("apb wait", 1, n);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      rd(8'h14);
      n++;
    end while (rdat[0] !== 1'b1 && n < 400);
    chk("ready wait", 1, rdat[0]);
  endtask

  task automatic t_reset;
    rd(8'h18);
    chk("cfg reset", 0, rdat);
    wr(8'h14, 32'hff);
    rd(8'h14);
    chk("status", 0, rdat);
    rd(8'h3c);
    chk("unmapped err", 1, rerr);
    chk("unmapped data", 0, rdat);
  endtask

  // Every code of every field, reserved ones included
  task automatic t_cfg;
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, 32'h55 * i);
      rd(8'h18);
      chk("cfg", 32'h55 * i, rdat);
    end
  endtask

  task automatic t_fifo_test;
    wr(8'h18, 32'hc0);
    wr(8'h00, 32'h5a);
    rd(8'h14);
    chk("ready set", 1, rdat);
    // Left unread for more than 16 sample ticks the byte times out
    repeat (700) @(posedge clk);
    rd(8'h14);
    chk("idle timeout", 5, rdat);
    rd(8'h00);
    chk("test byte", 32'h5a, rdat);
    rd(8'h14);
    chk("ready gone", 0, rdat);
  endtask

  // Steady low pin: eight samples make one byte of the decoded level
  task automatic t_oversample;
    wr(8'h18, 32'h4d);
    wait_rdy;
    rd(8'h00);
    chk("over byte", 32'hff, rdat);
    wr(8'h18, 32'h8c);
    wait_rdy;
    rd(8'h00);
    chk("resync byte", 32'h00, rdat);
  endtask

  task automatic cnt_baud(input logic [7:0] c, input int lo, input int hi);
    logic [31:0] n;
    wr(8'h18, {24'h0, c});
    n = 0;
    repeat (1300) begin
      @(posedge clk);
      n = n + baud_tick;
    end
    chk_rng("baud ticks", lo, hi, n);
  endtask

  // Low run then a ten period burst; reader keeps pace with the decoder
  // Flip is set where the chosen path or the invert bit delivers the pin inverted
  task automatic period_run(input logic [7:0] c, input logic flip);
    wr(8'h18, {24'h0, c});
    fork
      ir_remote_model_i.burst(170, 333);
      begin
        wait_rdy;
        rd(8'h00);
        chk("first value", !flip, rdat[7]);
      end
    join
    wait_rdy;
    rd(8'h00);
    chk("burst value", flip, rdat[7]);
    chk_rng("burst run", 8, 10, {25'h0, rdat[6:0]});
    rd(8'h14);
    chk("drained", 0, rdat[0]);
  endtask

  task automatic t_ovr;
    wr(8'h18, 32'h0c);
    frame_status_timeout <= 1'b1;
    @(posedge clk);
    frame_status_timeout <= 1'b0;
    repeat (4) ir_remote_model_i.burst(100, 100);
    repeat (60) @(posedge clk);
    rd(8'h14);
    chk("status full", 7, rdat);
    rd(8'h00);
    rd(8'h14);
    chk("status cleared", 0, rdat);
    rd(8'h20);
    chk("int overrun", 1, rdat[1]);
    chk("irq masked", 0, irq);
    wr(8'h24, 32'h2);
    @(posedge clk);
    chk("irq on", 1, irq);
    wr(8'h20, 32'h2);
    @(posedge clk);
    chk("irq cleared", 0, irq);
    wr(8'h24, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(25 * 40000);
    err_count++;
    tally_and_finish;
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    frame_status_timeout = 1'b0;
    bit_period_div = 16'd20;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_cfg;
    t_fifo_test;
    cnt_baud(8'h00, 779, 781);
    cnt_baud(8'h02, 59, 61);
    period_run(8'h0c, 1'b0);
    period_run(8'h2d, 1'b1);
    period_run(8'h20, 1'b1);
    period_run(8'h14, 1'b0);
    t_oversample;
    t_ovr;
    tally_and_finish;
  end
endmodule
`default_nettype wire
